//--- ods_bus_model.sv
// Bus front-end model: left and right external cycles of each internal cycle
`timescale 1ns/1ps
module ods_bus_model (
  input  wire logic          i_clk,
  output ods_pkg::ods_slot_s o_slot_l,
  output ods_pkg::ods_slot_s o_slot_r
);
  // Bus starts released, both slots carry no-operations
  initial begin
    o_slot_l = '0;
    o_slot_r = '0;
  end

  // One internal cycle, launched after the edge and held until the next edge
  task automatic put(input ods_pkg::ods_slot_s l, input ods_pkg::ods_slot_s r);
    @(posedge i_clk);
    o_slot_l <= l;
    o_slot_r <= r;
  endtask

  // Released bus: no-operation with inverted payload so stale data never matches
  task automatic rel();
    @(posedge i_clk);
    o_slot_l <= '{ods_pkg::K_NOP, 1'b0, 2'h0, ~o_slot_l.addr, ~o_slot_l.data};
    o_slot_r <= '{ods_pkg::K_NOP, 1'b0, 2'h0, ~o_slot_r.addr, ~o_slot_r.data};
  endtask
endmodule

//--- ods_decoder.sv
// Outbound dual-slot decode stage with sequencer, staging and prefetch return
// How it works
// - Left and right slots decode in parallel, each choosing address and data destination.
// - Single-cycle transactions finish in idle with no wait state.
// - Right-slot first cycle waits: write short 1, copy 4, read return 3.
// - Distinct-destination slot pairs both accepted every internal cycle, never stalling.
// - Nop, idle or foreign-module slots are free and never conflict.
// - Coherency checks from both slots run together; two entries per cycle.
// - Errors are logged; of two in one cycle only higher priority kept, the left slot on equal priority.
// - Sync transactions from both slots answered in parallel, two per cycle.
// - Data beats of multi-cycle transactions go into staging registers.
// - Each slot decoder owns two staging registers.
// - RAM writes are 128-bit words built from two consecutive beats.
// - Requested resident prefetch is appended to the read return queue.
// - Prefetch enqueue waits while both slots carry valid address or data.
// - When the path frees with no final data beat and room in the queue, prefetch is enqueued and buffer valid cleared together.
// - Inbound may refill the prefetch buffer only after seeing it invalid.
// - Wait state holds pending count; one pending is held in idle.
// - Header held until data stored; final data beat of a copy or read return pushes it to read return queue.
`timescale 1ns/1ps
module ods_decoder (
  input  wire logic                          i_clk,
  input  wire logic                          i_reset,
  input  wire ods_pkg::ods_slot_s            i_slot_l,
  input  wire ods_pkg::ods_slot_s            i_slot_r,
  input  wire logic                          i_pf_fill,
  input  wire logic [ods_pkg::ADDR_W-1:0]    i_pf_addr,
  input  wire logic                          i_pf_request,
  input  wire logic                          i_rrq_ready,
  output logic                               o_rrq_valid,
  output ods_pkg::ods_rrq_s                  o_rrq_data,
  output ods_pkg::ods_cmd_s [1:0]            o_cmd,
  output logic [1:0]                         o_coh,
  output logic [1:0]                         o_sync,
  output ods_pkg::ods_err_s                  o_err,
  output logic                               o_ram_we,
  output logic [ods_pkg::ADDR_W-1:0]         o_ram_addr,
  output logic [ods_pkg::WORD_W-1:0]         o_ram_word,
  output logic                               o_pf_valid,
  output logic [ods_pkg::CNT_W-1:0]          o_wait_cnt,
  output logic                               o_rrq_overflow
);
  typedef logic [ods_pkg::BEAT_W-1:0] ods_beat_t;

  ods_pkg::ods_slot_s            slot [2];
  logic [1:0]                    busy;
  logic [2:0]                    cnt_q, cnt_d;
  ods_pkg::ods_txn_e             cur_q, cur_d;
  ods_pkg::ods_seq_e             st_q, st_d;
  logic [ods_pkg::ADDR_W-1:0]    hdr_q, hdr_d, fin_hdr;
  logic                          half_q, half_d, lo_sl_q, lo_sl_d;
  ods_beat_t                     stg_q [2][2];
  ods_beat_t                     stg_d [2][2];
  ods_pkg::ods_cmd_s [1:0]       cmd_q, cmd_d;
  logic                          ram_we_q, ram_we_d;
  logic [ods_pkg::ADDR_W-1:0]    ram_addr_q, ram_addr_d;
  logic [ods_pkg::WORD_W-1:0]    ram_word_q, ram_word_d;
  logic                          fin_rrq;
  logic [1:0]                    coh_q, coh_d, sync_q, sync_d;
  ods_pkg::ods_err_s             err_q, err_d;
  logic                          pf_valid_q, pf_valid_d, pf_req_q, pf_req_d;
  logic [ods_pkg::ADDR_W-1:0]    pf_addr_q, pf_addr_d;
  logic                          pf_push, path_free, rrq_ready;
  logic                          ovf_q, ovf_d;
  logic                          push;
  ods_pkg::ods_rrq_s             push_data;

  // A slot with a nop or a transaction for another module is free
  function automatic logic is_free(input ods_pkg::ods_slot_s s);
    return (s.kind == ods_pkg::K_NOP) || s.foreign;
  endfunction

  // Pending data cycles loaded by a first cycle
  function automatic logic [2:0] wait_of(input ods_pkg::ods_kind_e k);
    unique case (k)
      ods_pkg::K_WRS: return ods_pkg::WAIT_WRS;
      ods_pkg::K_C2C: return ods_pkg::WAIT_C2C;
      ods_pkg::K_MRR: return ods_pkg::WAIT_MRR;
      default:        return ods_pkg::RST_CNT;
    endcase
  endfunction

  // Sequencer state from the pending count; one pending stays idle
  function automatic ods_pkg::ods_seq_e seq_of(input logic [2:0] c);
    unique case (c)
      3'h2:    return ods_pkg::SQ_W2;
      3'h3:    return ods_pkg::SQ_W3;
      3'h4:    return ods_pkg::SQ_W4;
      default: return ods_pkg::SQ_IDLE;
    endcase
  endfunction

  assign slot[0]   = i_slot_l;
  assign slot[1]   = i_slot_r;
  assign busy[0]   = !is_free(i_slot_l);
  assign busy[1]   = !is_free(i_slot_r);

  // Sequencer, staging registers and RAM word assembly across both slots
  always_comb begin
    cnt_d      = cnt_q;
    cur_d      = cur_q;
    hdr_d      = hdr_q;
    half_d     = half_q;
    lo_sl_d    = lo_sl_q;
    stg_d      = stg_q;
    cmd_d      = '0;
    ram_we_d   = 1'b0;
    ram_word_d = ram_word_q;
    ram_addr_d = ram_addr_q;
    fin_rrq    = 1'b0;
    fin_hdr    = hdr_q;
    for (int i = 0; i < 2; i++) begin
      if (busy[i]) begin
        unique case (slot[i].kind)
          ods_pkg::K_DATA: begin
            if (cnt_d != ods_pkg::RST_CNT) begin
              stg_d[i][half_d] = slot[i].data;
              cnt_d = cnt_d - 3'h1;
              if (cur_d == ods_pkg::T_WRS) begin
                cmd_d[i] = '{valid: 1'b1, wr: 1'b1, addr: hdr_d, data: slot[i].data};
              end else if (half_d) begin
                ram_we_d   = 1'b1;
                ram_word_d = {slot[i].data, stg_d[lo_sl_d][1'b0]};
                ram_addr_d = hdr_d;
                half_d     = 1'b0;
              end else begin
                lo_sl_d = i[0];
                half_d  = 1'b1;
              end
              if (cnt_d == ods_pkg::RST_CNT) begin
                if (cur_d != ods_pkg::T_WRS) begin
                  fin_rrq = 1'b1;
                  fin_hdr = hdr_d;
                end
                cur_d = ods_pkg::T_NONE;
              end
            end
          end
          ods_pkg::K_WRS, ods_pkg::K_C2C, ods_pkg::K_MRR: begin
            hdr_d  = slot[i].addr;
            half_d = 1'b0;
            cnt_d  = wait_of(slot[i].kind);
            cur_d  = (slot[i].kind == ods_pkg::K_WRS) ? ods_pkg::T_WRS :
                     (slot[i].kind == ods_pkg::K_C2C) ? ods_pkg::T_C2C : ods_pkg::T_MRR;
          end
          ods_pkg::K_RDS: begin
            cmd_d[i] = '{valid: 1'b1, wr: 1'b0, addr: slot[i].addr, data: '0};
          end
          ods_pkg::K_COH, ods_pkg::K_ERR, ods_pkg::K_SYNC: begin
          end
          default: begin
          end
        endcase
      end
    end
    st_d = seq_of(cnt_d);
  end

  // Coherency, sync and error routing; both slots in one cycle
  always_comb begin
    err_d = '0;
    for (int i = 0; i < 2; i++) begin
      coh_d[i]  = busy[i] && (slot[i].kind == ods_pkg::K_COH);
      sync_d[i] = busy[i] && (slot[i].kind == ods_pkg::K_SYNC);
    end
    if (busy[0] && slot[0].kind == ods_pkg::K_ERR) begin
      err_d = '{valid: 1'b1, slot: 1'b0, prio: slot[0].prio, addr: slot[0].addr};
    end
    if (busy[1] && slot[1].kind == ods_pkg::K_ERR &&
        (!err_d.valid || slot[1].prio > err_d.prio)) begin
      err_d = '{valid: 1'b1, slot: 1'b1, prio: slot[1].prio, addr: slot[1].addr};
    end
  end

  // Prefetch buffer tracking and read return queue feed
  always_comb begin
    path_free  = !(busy[0] && busy[1]);
    pf_push    = pf_req_q && pf_valid_q && path_free && !fin_rrq && rrq_ready;
    pf_valid_d = pf_valid_q;
    pf_addr_d  = pf_addr_q;
    if (pf_push) begin
      pf_valid_d = 1'b0;
    end else if (i_pf_fill && !pf_valid_q) begin
      pf_valid_d = 1'b1;
      pf_addr_d  = i_pf_addr;
    end
    pf_req_d  = (pf_req_q || (i_pf_request && pf_valid_q)) && !pf_push;
    push      = fin_rrq || pf_push;
    push_data = fin_rrq ? '{prefetch: 1'b0, addr: fin_hdr} :
                          '{prefetch: 1'b1, addr: pf_addr_q};
    ovf_d     = ovf_q || (fin_rrq && !rrq_ready);
  end

  // Read return queue
  ods_fifo #(
    .W     ($bits(ods_pkg::ods_rrq_s)),
    .DEPTH (ods_pkg::RRQ_DEPTH)
  ) u_rrq (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_in_valid  (push),
    .o_in_ready  (rrq_ready),
    .i_in_data   (push_data),
    .o_out_valid (o_rrq_valid),
    .i_out_ready (i_rrq_ready),
    .o_out_data  (o_rrq_data)
  );

  // Register stage
  always_ff @(posedge i_clk) begin
    stg_q      <= stg_d;
    ram_word_q <= ram_word_d;
    ram_addr_q <= ram_addr_d;
    hdr_q      <= hdr_d;
    pf_addr_q  <= pf_addr_d;
    if (i_reset) begin
      cnt_q      <= ods_pkg::RST_CNT;
      cur_q      <= ods_pkg::T_NONE;
      st_q       <= ods_pkg::SQ_IDLE;
      half_q     <= ods_pkg::RST_FLAG;
      lo_sl_q    <= ods_pkg::RST_FLAG;
      cmd_q      <= '0;
      ram_we_q   <= ods_pkg::RST_FLAG;
      coh_q      <= '0;
      sync_q     <= '0;
      err_q      <= '0;
      pf_valid_q <= ods_pkg::RST_FLAG;
      pf_req_q   <= ods_pkg::RST_FLAG;
      ovf_q      <= ods_pkg::RST_FLAG;
    end else begin
      cnt_q      <= cnt_d;
      cur_q      <= cur_d;
      st_q       <= st_d;
      half_q     <= half_d;
      lo_sl_q    <= lo_sl_d;
      cmd_q      <= cmd_d;
      ram_we_q   <= ram_we_d;
      coh_q      <= coh_d;
      sync_q     <= sync_d;
      err_q      <= err_d;
      pf_valid_q <= pf_valid_d;
      pf_req_q   <= pf_req_d;
      ovf_q      <= ovf_d;
    end
  end

  // Outputs, all from flip-flops except the queue handshake
  assign o_cmd          = cmd_q;
  assign o_coh          = coh_q;
  assign o_sync         = sync_q;
  assign o_err          = err_q;
  assign o_ram_we       = ram_we_q;
  assign o_ram_addr     = ram_addr_q;
  assign o_ram_word     = ram_word_q;
  assign o_pf_valid     = pf_valid_q;
  assign o_wait_cnt     = cnt_q;
  assign o_rrq_overflow = ovf_q;

  // Checks on sequencer, routing and prefetch behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  wrs_wait_a: assert property (
    busy[1] && i_slot_r.kind == ods_pkg::K_WRS |=> cnt_q == 3'h1 && st_q == ods_pkg::SQ_IDLE)
    else $error("write short did not wait for one");
  c2c_wait_a: assert property (
    busy[1] && i_slot_r.kind == ods_pkg::K_C2C |=> cnt_q == 3'h4 && st_q == ods_pkg::SQ_W4)
    else $error("copy did not wait for four");
  mrr_wait_a: assert property (
    busy[1] && i_slot_r.kind == ods_pkg::K_MRR |=> cnt_q == 3'h3 && st_q == ods_pkg::SQ_W3)
    else $error("read return did not wait for three");
  single_idle_a: assert property (
    cnt_q == 3'h0 && !busy[0] && busy[1] && i_slot_r.kind inside
      {ods_pkg::K_COH, ods_pkg::K_RDS, ods_pkg::K_SYNC, ods_pkg::K_ERR}
      |=> st_q == ods_pkg::SQ_IDLE && cnt_q == 3'h0)
    else $error("single cycle transaction left idle");
  beat_count_a: assert property (
    cnt_q == 3'h3 && busy[0] && i_slot_l.kind == ods_pkg::K_DATA && !busy[1]
      |=> cnt_q == 3'h2 && st_q == ods_pkg::SQ_W2)
    else $error("pending count not decremented per beat");
  coh_pair_a: assert property (
    busy == 2'b11 && i_slot_l.kind == ods_pkg::K_COH && i_slot_r.kind == ods_pkg::K_COH
      |=> o_coh == 2'b11)
    else $error("two coherency checks not taken together");
  sync_pair_a: assert property (
    busy == 2'b11 && i_slot_l.kind == ods_pkg::K_SYNC && i_slot_r.kind == ods_pkg::K_SYNC
      |=> o_sync == 2'b11)
    else $error("two syncs not taken together");
  err_prio_a: assert property (
    busy == 2'b11 && i_slot_l.kind == ods_pkg::K_ERR && i_slot_r.kind == ods_pkg::K_ERR
      && i_slot_r.prio > i_slot_l.prio |=> o_err.valid && o_err.slot)
    else $error("lower priority error logged");
  free_slot_a: assert property (
    i_slot_l.foreign && i_slot_r.foreign |=> o_coh == 2'b00 && !o_err.valid && !o_cmd[0].valid)
    else $error("foreign slot was decoded");
  pf_defer_a: assert property (
    pf_valid_q && busy == 2'b11 |=> pf_valid_q)
    else $error("prefetch enqueued while bus busy");
  pf_clear_a: assert property (
    $fell(pf_valid_q) |-> $past(pf_push) && $past(push_data.prefetch))
    else $error("prefetch valid cleared without enqueue");
  pair_word_a: assert property (
    cnt_q == 3'h3 && cur_q == ods_pkg::T_MRR && !half_q && busy == 2'b11
      && i_slot_l.kind == ods_pkg::K_DATA && i_slot_r.kind == ods_pkg::K_DATA
      |=> o_ram_we && o_ram_word == {$past(i_slot_r.data), $past(i_slot_l.data)})
    else $error("two beats did not form one RAM word");

  both_accept_c: cover property (busy == 2'b11 && i_slot_l.kind == ods_pkg::K_COH
    && i_slot_r.kind == ods_pkg::K_MRR);
  final_store_c: cover property (fin_rrq);
  pf_return_c:   cover property (pf_push);
  wrs_cmd_c:     cover property (cmd_d[0].valid && cmd_d[0].wr);
endmodule

//--- ods_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ods_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  // Honest full and empty from the fill count
  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // Pointer and storage next values
  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = i_in_data;
      wr_d        = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge i_clk) begin
    mem_q <= mem_d;
    if (i_reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

//--- ods_pkg.sv
// Shared constants and types for the outbound dual-slot decoder
package ods_pkg;
  localparam int ADDR_W     = 32;
  localparam int BEAT_W     = 64;
  localparam int WORD_W     = 128;
  localparam int RRQ_DEPTH  = 8;
  localparam int CNT_W      = 3;

  // Pending data cycles loaded by the first cycle of each multi-cycle transaction
  localparam logic [2:0] WAIT_WRS = 3'h1;
  localparam logic [2:0] WAIT_C2C = 3'h4;
  localparam logic [2:0] WAIT_MRR = 3'h3;

  // Reset values
  localparam logic [2:0] RST_CNT  = 3'h0;
  localparam logic       RST_FLAG = 1'h0;

  // Kind of one external bus cycle as seen by a slot decoder
  typedef enum logic [3:0] {
    K_NOP, K_COH, K_RDS, K_ERR, K_SYNC, K_WRS, K_C2C, K_MRR, K_DATA
  } ods_kind_e;

  // Multi-cycle transaction in progress
  typedef enum logic [1:0] {T_NONE, T_WRS, T_C2C, T_MRR} ods_txn_e;

  // Sequencer states; one pending cycle is held in idle
  typedef enum logic [1:0] {SQ_IDLE, SQ_W2, SQ_W3, SQ_W4} ods_seq_e;

  typedef struct packed {
    ods_kind_e           kind;
    logic                foreign;
    logic [1:0]          prio;
    logic [ADDR_W-1:0]   addr;
    logic [BEAT_W-1:0]   data;
  } ods_slot_s;

  typedef struct packed {
    logic                valid;
    logic                wr;
    logic [ADDR_W-1:0]   addr;
    logic [BEAT_W-1:0]   data;
  } ods_cmd_s;

  typedef struct packed {
    logic                valid;
    logic                slot;
    logic [1:0]          prio;
    logic [ADDR_W-1:0]   addr;
  } ods_err_s;

  typedef struct packed {
    logic                prefetch;
    logic [ADDR_W-1:0]   addr;
  } ods_rrq_s;
endpackage

//--- tb_outbound_dual_slot_decoder.sv
// Self-checking testbench for the outbound dual-slot decoder
`timescale 1ns/1ps
module tb_outbound_dual_slot_decoder;
  logic                     clk;
  logic                     rst;
  ods_pkg::ods_slot_s       sl_l;
  ods_pkg::ods_slot_s       sl_r;
  logic                     pf_fill;
  logic [31:0]              pf_addr;
  logic                     pf_req;
  logic                     rrq_rdy;
  logic                     rrq_vld;
  ods_pkg::ods_rrq_s        rrq_dat;
  ods_pkg::ods_cmd_s [1:0]  cmd;
  logic [1:0]               coh;
  logic [1:0]               sync;
  ods_pkg::ods_err_s        err;
  logic                     ram_we;
  logic [31:0]              ram_addr;
  logic [127:0]             ram_word;
  logic                     pf_vld;
  logic [2:0]               wcnt;
  logic                     ovf;
  int                       err_total;
  int                       n_checks;

  ods_bus_model bm (.i_clk(clk), .o_slot_l(sl_l), .o_slot_r(sl_r));

  ods_decoder dut (
    .i_clk(clk), .i_reset(rst), .i_slot_l(sl_l), .i_slot_r(sl_r),
    .i_pf_fill(pf_fill), .i_pf_addr(pf_addr), .i_pf_request(pf_req),
    .i_rrq_ready(rrq_rdy), .o_rrq_valid(rrq_vld), .o_rrq_data(rrq_dat),
    .o_cmd(cmd), .o_coh(coh), .o_sync(sync), .o_err(err), .o_ram_we(ram_we),
    .o_ram_addr(ram_addr), .o_ram_word(ram_word), .o_pf_valid(pf_vld),
    .o_wait_cnt(wcnt), .o_rrq_overflow(ovf)
  );

  // Clock of 8 ns period
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Compare and count
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Slot builders
  function automatic ods_pkg::ods_slot_s sl(input ods_pkg::ods_kind_e k,
      input logic [31:0] a = '0, input logic [1:0] p = 2'h0, input logic f = 1'b0);
    sl = '{k, f, p, a, 64'h0};
  endfunction
  function automatic ods_pkg::ods_slot_s dt(input logic [63:0] d);
    dt = '{ods_pkg::K_DATA, 1'b0, 2'h0, 32'h0, d};
  endfunction

  // Drain a single queue entry
  task automatic pop();
    @(posedge clk);
    rrq_rdy <= 1'b1;
    @(posedge clk);
    rrq_rdy <= 1'b0;
    #1 chk("rrq_valid", 1'b0, rrq_vld);
  endtask

  // Single-cycle pairs, error priority, foreign slots
  task automatic t_single();
    bm.put(sl(ods_pkg::K_COH), sl(ods_pkg::K_COH));
    bm.put(sl(ods_pkg::K_SYNC), sl(ods_pkg::K_SYNC));
    #1 chk("coh", 2'h3, coh);
    chk("wait", 3'h0, wcnt);
    bm.put(sl(ods_pkg::K_ERR, 32'h11, 2'h1), sl(ods_pkg::K_ERR, 32'h22, 2'h2));
    #1 chk("sync", 2'h3, sync);
    bm.put(sl(ods_pkg::K_ERR, 32'h33, 2'h2), sl(ods_pkg::K_ERR, 32'h44, 2'h2));
    #1 chk("err", {1'b1, 1'b1, 2'h2, 32'h22}, err);
    bm.put(sl(ods_pkg::K_RDS, 32'h55), sl(ods_pkg::K_COH));
    #1 chk("err", {1'b1, 1'b0, 2'h2, 32'h33}, err);
    bm.put(sl(ods_pkg::K_COH, '0, 2'h0, 1'b1), sl(ods_pkg::K_ERR, 32'h66, 2'h0, 1'b1));
    #1 chk("cmd0", {2'h2, 32'h55}, {cmd[0].valid, cmd[0].wr, cmd[0].addr});
    chk("coh", 2'h2, coh);
    bm.rel();
    #1 chk("coh", 2'h0, coh);
    chk("err_valid", 1'b0, err.valid);
    chk("wait", 3'h0, wcnt);
    bm.put(sl(ods_pkg::K_NOP), sl(ods_pkg::K_RDS, 32'h77));
    bm.rel();
    #1 chk("cmd1", {2'h2, 32'h77}, {cmd[1].valid, cmd[1].wr, cmd[1].addr});
    chk("cmd0_valid", 1'b0, cmd[0].valid);
    chk("wait", 3'h0, wcnt);
    $display("test single done");
  endtask

  // Write short: one data beat to the command queue
  task automatic t_wrs(input logic [31:0] a);
    bm.put(sl(ods_pkg::K_NOP), sl(ods_pkg::K_WRS, a));
    bm.put(dt({a, ~a}), sl(ods_pkg::K_WRS, ~a));
    #1 chk("wait", 3'h1, wcnt);
    bm.put(sl(ods_pkg::K_NOP), dt({~a, a}));
    #1 chk("cmd0", {2'h3, a, a, ~a}, cmd[0]);
    chk("wait", 3'h1, wcnt);
    bm.rel();
    #1 chk("cmd1", {2'h3, ~a, ~a, a}, cmd[1]);
    chk("cmd0_valid", 1'b0, cmd[0].valid);
    chk("wait", 3'h0, wcnt);
    $display("test write short done");
  endtask

  // Memory read return: three beats, one RAM word, odd beat staged
  task automatic mrr(input logic [31:0] a);
    bm.put(sl(ods_pkg::K_NOP), sl(ods_pkg::K_MRR, a));
    bm.put(dt({a, ~a}), dt({~a, a}));
    #1 chk("wait", 3'h3, wcnt);
    bm.put(dt({a, a}), sl(ods_pkg::K_NOP));
    #1 chk("wait", 3'h1, wcnt);
    chk("ram_we", 1'b1, ram_we);
    chk("ram_word", {~a, a, a, ~a}, ram_word);
    chk("ram_addr", a, ram_addr);
    bm.rel();
    #1 chk("wait", 3'h0, wcnt);
    chk("ram_we", 1'b0, ram_we);
  endtask

  // Cache-to-cache copy: four beats back to back in both slots
  task automatic t_c2c(input logic [31:0] a);
    bm.put(sl(ods_pkg::K_NOP), sl(ods_pkg::K_C2C, a));
    bm.put(dt({a, ~a}), dt({~a, a}));
    #1 chk("wait", 3'h4, wcnt);
    bm.put(dt({a, a}), dt({~a, ~a}));
    #1 chk("wait", 3'h2, wcnt);
    chk("ram_word", {~a, a, a, ~a}, ram_word);
    bm.rel();
    #1 chk("ram_word", {~a, ~a, a, a}, ram_word);
    chk("ram_we", 1'b1, ram_we);
    chk("rrq_data", {1'b0, a}, rrq_dat);
    pop();
    $display("test copy done");
  endtask

  // Prefetch return, deferred for n busy cycles, refill attempt ignored
  task automatic t_pf(input logic [31:0] a, input int n);
    int k;
    @(posedge clk);
    pf_fill <= 1'b1;
    pf_addr <= a;
    bm.rel();
    pf_addr <= ~a;
    pf_req  <= 1'b1;
    #1 chk("pf_valid", 1'b1, pf_vld);
    for (k = 0; k < n; k++) begin
      bm.put(sl(ods_pkg::K_COH), sl(ods_pkg::K_SYNC));
      pf_req  <= 1'b0;
      pf_fill <= 1'b0;
    end
    bm.rel();
    pf_req  <= 1'b0;
    pf_fill <= 1'b0;
    #1 if (n > 0) chk("pf_valid", 1'b1, pf_vld);
    k = 0;
    while (pf_vld !== 1'b0 && k < 5) begin
      @(posedge clk);
      #1 k++;
    end
    chk("pf_valid", 1'b0, pf_vld);
    chk("rrq_valid", 1'b1, rrq_vld);
    chk("rrq_data", {1'b1, a}, rrq_dat);
    pop();
    $display("test prefetch done");
  endtask

  // Queue filled past its depth while the consumer stalls, then drained
  task automatic t_fill();
    int i;
    for (i = 0; i < 9; i++) mrr(32'h0000_0200 + i);
    @(posedge clk);
    rrq_rdy <= 1'b1;
    #1 chk("overflow", 1'b1, ovf);
    for (i = 0; i < 8; i++) begin
      #1 chk("rrq_data", {1'b0, 32'h0000_0200 + i}, rrq_dat);
      @(posedge clk);
    end
    rrq_rdy <= 1'b0;
    #1 chk("rrq_valid", 1'b0, rrq_vld);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1 chk("overflow", 1'b0, ovf);
    // Read return beats split over the halves of later internal cycles
    bm.put(sl(ods_pkg::K_NOP), sl(ods_pkg::K_MRR, 32'h0000_0400));
    bm.put(dt(64'h1111_2222_3333_4444), sl(ods_pkg::K_NOP));
    bm.put(sl(ods_pkg::K_NOP), dt(64'h5555_6666_7777_8888));
    #1 chk("wait", 3'h2, wcnt);
    chk("ram_we", 1'b0, ram_we);
    bm.put(dt(64'h9999_AAAA_BBBB_CCCC), sl(ods_pkg::K_NOP));
    #1 chk("ram_word", 128'h5555_6666_7777_8888_1111_2222_3333_4444, ram_word);
    chk("wait", 3'h1, wcnt);
    bm.rel();
    #1 chk("rrq_data", {1'b0, 32'h0000_0400}, rrq_dat);
    chk("rrq_valid", 1'b1, rrq_vld);
    pop();
    $display("test fill done");
  endtask

  // Verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    end_sim();
  end

  // Main sequence
  initial begin
    err_total = 0;
    n_checks  = 0;
    rst       = 1'b1;
    pf_fill   = 1'b0;
    pf_addr   = 32'h0;
    pf_req    = 1'b0;
    rrq_rdy   = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1 chk("pf_valid", 1'b0, pf_vld);
    chk("wait", 3'h0, wcnt);
    chk("rrq_valid", 1'b0, rrq_vld);
    t_single();
    t_wrs(32'h0000_0100);
    t_c2c(32'h0000_0140);
    t_pf(32'h0000_0300, 0);
    t_pf(32'h0000_0340, 4);
    t_fill();
    end_sim();
  end
endmodule
